// *** hw/spslo_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module spslo_top
  import spslo_pkg::*;
#(
  parameter int EN_W = SPSLO_EN_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic device_reset_n,
  input wire logic chan_a_primary_serial_in,
  input wire logic chan_a_secondary_serial_in,
  input wire logic chan_b_primary_serial_in,
  input wire logic chan_b_secondary_serial_in,
  input wire logic chan_a_tx_serial,
  input wire logic chan_b_tx_serial,
  output logic chan_a_cdr_in,
  output logic chan_b_cdr_in,
  output logic chan_a_primary_serial_out,
  output logic chan_a_secondary_serial_out,
  output logic chan_b_primary_serial_out,
  output logic chan_b_secondary_serial_out,
  output logic [EN_W-1:0] driver_enable,
  output logic [1:0] signal_detect_level_select
);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  // The pin packing and the status layout are fixed at four drivers.
  generate
    if (EN_W != SPSLO_EN_W) begin : g_bad_en_w
      $error("spslo_top: EN_W must be four");
    end
  endgenerate

  // ---------------------------------------------------------------
  // State and nets
  // ---------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic wr_pend_q;
  logic wr_pend_d;
  logic [31:0] addr_q;
  logic [31:0] addr_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] rd_word;
  logic [31:0] addr_now;
  logic [EN_W-1:0] en_latch_q;
  logic [EN_W-1:0] en_latch_d;
  logic [SPSLO_SYNC_W-1:0] pin_raw;
  logic [SPSLO_SYNC_W-1:0] pin_s1_q;
  logic [SPSLO_SYNC_W-1:0] pin_s2_q;
  logic [SPSLO_SERIN_W-1:0] serin_s;
  logic [SPSLO_CHAN_N-1:0] tx_s;
  logic dev_rst_n_s;
  logic [SPSLO_CHAN_N-1:0] sel_chan;
  logic [EN_W-1:0] serout_q;
  logic [EN_W-1:0] serout_d;
  logic [SPSLO_CHAN_N-1:0] cdr_q;
  logic [SPSLO_CHAN_N-1:0] cdr_d;
  logic trans_ok;
  logic size_ok;
  logic acc;
  logic rd_acc;
  logic wr_acc;
  logic sel_a;
  logic sel_b;
  logic loop_en;
  logic latch_open;
  logic [EN_W-1:0] en_bus;

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------
  // The slave never stretches a transfer, so the bus runs at full rate
  // and software never has to poll for a slow answer.
  assign trans_ok = (htrans == SPSLO_HTRANS_NONSEQ);
  assign size_ok = (hsize == SPSLO_HSIZE_WORD);
  assign acc = hsel && hready && trans_ok && size_ok;
  assign rd_acc = acc && !hwrite;
  assign wr_acc = acc && hwrite;
  assign addr_now = haddr & SPSLO_ADDR_MASK;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  assign sel_a = ctrl_q[SPSLO_CTRL_SEL_A];
  assign sel_b = ctrl_q[SPSLO_CTRL_SEL_B];
  assign loop_en = ctrl_q[SPSLO_CTRL_LOOP];
  assign latch_open = ctrl_q[SPSLO_CTRL_LATCH_OPEN];
  assign en_bus = ctrl_q[SPSLO_CTRL_ENBUS_LSB +: SPSLO_EN_W];

  // ---------------------------------------------------------------
  // Write path
  // ---------------------------------------------------------------
  // The data phase follows the taken address phase by one edge, so the
  // address is parked until hwdata stands.
  always_comb begin
    wr_pend_d = wr_acc;
    addr_d = acc ? addr_now : addr_q;
    ctrl_d = ctrl_q;
    if (wr_pend_q && (addr_q == SPSLO_CTRL_ADDR)) begin
      ctrl_d = hwdata;
      // The unused code would leave the detect threshold undefined, so
      // such a write keeps the level that was set before.
      if (hwdata[SPSLO_CTRL_SDL_LSB +: SPSLO_SDL_W] == SPSLO_SDL_BAD) begin
        ctrl_d[SPSLO_CTRL_SDL_LSB +: SPSLO_SDL_W] =
          ctrl_q[SPSLO_CTRL_SDL_LSB +: SPSLO_SDL_W];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= SPSLO_CTRL_RESET;
      wr_pend_q <= 1'b0;
      addr_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      wr_pend_q <= wr_pend_d;
      addr_q <= addr_d;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // The word is chosen in the address phase and registered, so it
  // stands on hrdata for the whole data phase.
  always_comb begin
    rd_word = '0;
    if (addr_now == SPSLO_CTRL_ADDR) begin
      rd_word = ctrl_q;
    end else if (addr_now == SPSLO_STATUS_ADDR) begin
      rd_word[SPSLO_STAT_EN_LSB +: SPSLO_EN_W] = en_latch_q;
      rd_word[SPSLO_STAT_LOOP] = loop_en;
      rd_word[SPSLO_STAT_OPEN] = latch_open;
    end
  end

  always_comb begin
    rdata_d = rdata_q;
    if (rd_acc) begin
      rdata_d = rd_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Serial pins are treated as slow levels here; the real CDR path is
  // analog and this model only carries the selection.
  assign pin_raw = {device_reset_n, chan_b_tx_serial, chan_a_tx_serial,
    chan_b_secondary_serial_in, chan_b_primary_serial_in,
    chan_a_secondary_serial_in, chan_a_primary_serial_in};

  // The device reset stage starts low, so the latch stays cleared until
  // a high level on the pin has passed both stages.
  genvar gs;
  generate
    for (gs = 0; gs < SPSLO_SYNC_W; gs++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pin_s1_q[gs] <= 1'b0;
          pin_s2_q[gs] <= 1'b0;
        end else begin
          pin_s1_q[gs] <= pin_raw[gs];
          pin_s2_q[gs] <= pin_s1_q[gs];
        end
      end
    end
  endgenerate

  assign serin_s = pin_s2_q[SPSLO_SERIN_W-1:0];
  assign tx_s = pin_s2_q[SPSLO_PIN_TX_LSB +: SPSLO_CHAN_N];
  assign dev_rst_n_s = pin_s2_q[SPSLO_PIN_RST];

  // ---------------------------------------------------------------
  // Output-enable latch
  // ---------------------------------------------------------------
  // Built as a clocked register: open copies the bus every edge, so on
  // the closing edge it keeps the last value seen while open. The cost
  // is one edge of delay against a true transparent latch.
  genvar gl;
  generate
    for (gl = 0; gl < EN_W; gl++) begin : g_latch
      always_comb begin
        en_latch_d[gl] = en_latch_q[gl];
        if (!dev_rst_n_s) begin
          en_latch_d[gl] = 1'b0;
        end else if (latch_open) begin
          en_latch_d[gl] = en_bus[gl];
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          en_latch_q[gl] <= 1'b0;
        end else begin
          en_latch_q[gl] <= en_latch_d[gl];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Receive selection
  // ---------------------------------------------------------------
  assign sel_chan[SPSLO_CHAN_A] = sel_a;
  assign sel_chan[SPSLO_CHAN_B] = sel_b;

  // A channel's primary and secondary inputs sit next to each other in
  // the enable order, so one index serves both maps.
  genvar gc;
  generate
    for (gc = 0; gc < SPSLO_CHAN_N; gc++) begin : g_chan
      always_comb begin
        if (loop_en) begin
          cdr_d[gc] = tx_s[gc];
        end else if (sel_chan[gc]) begin
          cdr_d[gc] = serin_s[gc * SPSLO_EN_PER_CHAN];
        end else begin
          cdr_d[gc] = serin_s[gc * SPSLO_EN_PER_CHAN + SPSLO_EN_A_SEC];
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cdr_q[gc] <= 1'b0;
        end else begin
          cdr_q[gc] <= cdr_d[gc];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Serial drivers
  // ---------------------------------------------------------------
  // A powered-down driver shows a steady low; loop-back forces only the
  // enabled drivers high.
  genvar gd;
  generate
    for (gd = 0; gd < EN_W; gd++) begin : g_drv
      always_comb begin
        serout_d[gd] = 1'b0;
        if (en_latch_q[gd]) begin
          serout_d[gd] = loop_en ? 1'b1
            : tx_s[gd / SPSLO_EN_PER_CHAN];
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          serout_q[gd] <= 1'b0;
        end else begin
          serout_q[gd] <= serout_d[gd];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Output pins
  // ---------------------------------------------------------------
  assign chan_a_cdr_in = cdr_q[SPSLO_CHAN_A];
  assign chan_b_cdr_in = cdr_q[SPSLO_CHAN_B];
  assign chan_a_primary_serial_out = serout_q[SPSLO_EN_A_PRI];
  assign chan_a_secondary_serial_out = serout_q[SPSLO_EN_A_SEC];
  assign chan_b_primary_serial_out = serout_q[SPSLO_EN_B_PRI];
  assign chan_b_secondary_serial_out = serout_q[SPSLO_EN_B_SEC];
  assign driver_enable = en_latch_q;
  assign signal_detect_level_select =
    ctrl_q[SPSLO_CTRL_SDL_LSB +: SPSLO_SDL_W];

endmodule : spslo_top

`default_nettype wire

// *** hw/spslo_pkg.sv ***
`default_nettype none

package spslo_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [31:0] SPSLO_CTRL_ADDR = 32'h0000_0000;
  localparam logic [31:0] SPSLO_STATUS_ADDR = 32'h0000_0004;
  localparam logic [31:0] SPSLO_ADDR_MASK = 32'h0000_00fc;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int SPSLO_CTRL_SEL_A = 0;
  localparam int SPSLO_CTRL_SEL_B = 1;
  localparam int SPSLO_CTRL_LOOP = 2;
  localparam int SPSLO_CTRL_LATCH_OPEN = 3;
  localparam int SPSLO_CTRL_ENBUS_LSB = 4;
  localparam int SPSLO_CTRL_SDL_LSB = 8;
  localparam logic [31:0] SPSLO_CTRL_RESET = 32'h0000_0003;

  // ---------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------
  localparam int SPSLO_STAT_EN_LSB = 0;
  localparam int SPSLO_STAT_LOOP = 4;
  localparam int SPSLO_STAT_OPEN = 5;

  // Enable bit order on the shared enable bus.
  localparam int SPSLO_EN_A_PRI = 0;
  localparam int SPSLO_EN_A_SEC = 1;
  localparam int SPSLO_EN_B_PRI = 2;
  localparam int SPSLO_EN_B_SEC = 3;
  localparam int SPSLO_EN_W = 4;

  // Three-level select encodings (low, mid, high).
  localparam logic [1:0] SPSLO_SDL_LOW = 2'h0;
  localparam logic [1:0] SPSLO_SDL_MID = 2'h1;
  localparam logic [1:0] SPSLO_SDL_HIGH = 2'h2;
  localparam logic [1:0] SPSLO_SDL_BAD = 2'h3;
  localparam int SPSLO_SDL_W = 2;

  // Channels and the packing of the synchronised pins.
  localparam int SPSLO_CHAN_N = 2;
  localparam int SPSLO_CHAN_A = 0;
  localparam int SPSLO_CHAN_B = 1;
  localparam int SPSLO_EN_PER_CHAN = 2;
  localparam int SPSLO_SERIN_W = 4;
  localparam int SPSLO_PIN_TX_LSB = 4;
  localparam int SPSLO_PIN_RST = 6;
  localparam int SPSLO_SYNC_W = 7;

  localparam logic [1:0] SPSLO_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] SPSLO_HSIZE_WORD = 3'h2;

endpackage : spslo_pkg

`default_nettype wire

// *** test/spslo_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module spslo_monitor #(
  parameter int EN_W = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic device_reset_n,
  input wire logic chan_a_primary_serial_out,
  input wire logic chan_a_secondary_serial_out,
  input wire logic chan_b_primary_serial_out,
  input wire logic chan_b_secondary_serial_out,
  input wire logic [EN_W-1:0] driver_enable
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // The pin passes two sync stages before the latch, so allow the delay.
  dev_clear_a: assert property (!device_reset_n [*6]
    |-> driver_enable == '0) else $error("latch not cleared");
  dev_quiet_a: assert property (!device_reset_n [*7]
    |-> !(chan_a_primary_serial_out | chan_a_secondary_serial_out
    | chan_b_primary_serial_out | chan_b_secondary_serial_out))
    else $error("driver on in reset");
  a_pri_off_a: assert property (!driver_enable[0] [*3]
    |-> !chan_a_primary_serial_out) else $error("a primary on");
  a_sec_off_a: assert property (!driver_enable[1] [*3]
    |-> !chan_a_secondary_serial_out) else $error("a secondary on");
  b_pri_off_a: assert property (!driver_enable[2] [*3]
    |-> !chan_b_primary_serial_out) else $error("b primary on");
  b_sec_off_a: assert property (!driver_enable[3] [*3]
    |-> !chan_b_secondary_serial_out) else $error("b secondary on");
  no_wait_a: assert property (hreadyout) else $error("wait state");
  okay_resp_a: assert property (!hresp) else $error("error response");
endmodule : spslo_monitor
`default_nettype wire

// *** test/spslo_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module spslo_host_model (
  input wire logic hclk,
  input wire logic [6:0] want,
  output logic [6:0] pins
);
  // Pins move only after an edge, like a host's own output registers.
  always_ff @(posedge hclk) begin
    pins <= want;
  end
endmodule : spslo_host_model
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
  import spslo_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0] htrans = 0, sdl;
  logic [2:0] hsize = 0;
  logic hreadyout, hresp, cdr_a, cdr_b;
  logic [3:0] so, en;
  logic [6:0] want = 7'h45, pins;
  int bad_count = 0, checked = 0;
  always #4 hclk = ~hclk;
  spslo_host_model spslo_host_model_inst (.hclk(hclk), .want(want),
    .pins(pins));
  spslo_top spslo_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .device_reset_n(pins[6]),
    .chan_a_primary_serial_in(pins[0]), .chan_a_secondary_serial_in(pins[1]),
    .chan_b_primary_serial_in(pins[2]), .chan_b_secondary_serial_in(pins[3]),
    .chan_a_tx_serial(pins[4]), .chan_b_tx_serial(pins[5]),
    .chan_a_cdr_in(cdr_a), .chan_b_cdr_in(cdr_b),
    .chan_a_primary_serial_out(so[0]), .chan_a_secondary_serial_out(so[1]),
    .chan_b_primary_serial_out(so[2]), .chan_b_secondary_serial_out(so[3]),
    .driver_enable(en), .signal_detect_level_select(sdl));
  task automatic chk(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= SPSLO_HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= SPSLO_HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    repeat (6) @(posedge hclk);
  endtask : bus
  task automatic results;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task automatic t_reset;
    bus(1'b0, SPSLO_CTRL_ADDR, 32'h0);
    chk("ctrl", r, SPSLO_CTRL_RESET);
    bus(1'b0, 32'h0000_0008, 32'h0);
    chk("unmapped", r, 32'h0);
    chk("enables", en, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_sel;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, SPSLO_CTRL_ADDR, i);
      chk("cdr a", cdr_a, i[0]);
      chk("cdr b", cdr_b, i[1]);
    end
    $display("selector test done");
  endtask : t_sel
  task automatic t_latch;
    want <= 7'h75;
    bus(1'b1, SPSLO_CTRL_ADDR, 32'h0000_015b);
    chk("open en", en, 32'h5);
    chk("outs", so, 32'h5);
    chk("level", sdl, 32'h1);
    bus(1'b1, SPSLO_CTRL_ADDR, 32'h0000_02a3);
    chk("held en", en, 32'h5);
    chk("level", sdl, 32'h2);
    bus(1'b0, SPSLO_STATUS_ADDR, 32'h0);
    chk("status", r, 32'h5);
    $display("latch test done");
  endtask : t_latch
  task automatic t_loop;
    want <= 7'h4f;
    bus(1'b1, SPSLO_CTRL_ADDR, 32'h0000_0007);
    chk("loop cdr", {cdr_b, cdr_a}, 32'h0);
    chk("loop outs", so, 32'h5);
    want <= 7'h5f;
    bus(1'b0, SPSLO_STATUS_ADDR, 32'h0);
    chk("loop stat", r, 32'h15);
    chk("loop cdr", {cdr_b, cdr_a}, 32'h1);
    $display("loop-back test done");
  endtask : t_loop
  task automatic t_dev;
    want <= 7'h0f;
    repeat (10) @(posedge hclk);
    chk("dev en", en, 32'h0);
    chk("dev outs", so, 32'h0);
    want <= 7'h4f;
    $display("device reset test done");
  endtask : t_dev
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_sel();
    t_latch();
    t_loop();
    t_dev();
    results();
  end
  initial begin
    #20us;
    bad_count++;
    results();
  end
endmodule : tb
bind spslo_top spslo_monitor #(.EN_W(EN_W)) spslo_monitor_inst (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .device_reset_n(device_reset_n),
  .chan_a_primary_serial_out(chan_a_primary_serial_out),
  .chan_a_secondary_serial_out(chan_a_secondary_serial_out),
  .chan_b_primary_serial_out(chan_b_primary_serial_out),
  .chan_b_secondary_serial_out(chan_b_secondary_serial_out),
  .driver_enable(driver_enable));
`default_nettype wire
